// ---- uccr_defs.vh ----
/*
  Constants for the per-channel control register bank: offsets, field positions,
  reset values and request codes. Assumes a request decoder ahead of this block
  that hands over one decoded vendor request at a time.
*/
`ifndef UCCR_DEFS_VH
`define UCCR_DEFS_VH
`define UCCR_OFS_CHAN_ON 8'h00
`define UCCR_OFS_PACING 8'h06
`define UCCR_OFS_VERSION 16'h0260
`define UCCR_OFS_LINK_STAT 16'h0262
`define UCCR_CHAN_A 8'h00
`define UCCR_CHAN_B 8'h02
`define UCCR_BIT_TX_EN 0
`define UCCR_BIT_RX_EN 1
`define UCCR_BIT_HALF_DUPLEX 3
`define UCCR_CHAN_ON_MASK 16'h0003
`define UCCR_PACING_MASK 16'h000F
`define UCCR_CHAN_ON_RST 16'h0000
`define UCCR_PACING_RST 16'h0000
`define UCCR_LINK_STAT_RST 16'h0000
`define UCCR_MODE_NONE 3'h0
`define UCCR_MODE_HW 3'h1
`define UCCR_MODE_SW 3'h2
`define UCCR_MODE_MD_RX 3'h3
`define UCCR_MODE_MD_ALL 3'h4
`define UCCR_REQ_GENERIC_WR 3'h1
`define UCCR_REQ_GENERIC_RD 3'h2
`define UCCR_REQ_VERSION_RD 3'h3
`define UCCR_REQ_LSTAT_WR 3'h4
`define UCCR_REQ_LSTAT_RD 3'h5
`define UCCR_OFS_PIN_DRIVE 8'h13
`define UCCR_OFS_PULL_HIGH 8'h14
`define UCCR_OFS_PULL_LOW 8'h15
`define UCCR_OFS_WRAP 8'h16
`define UCCR_OFS_INFRARED 8'h17
`define UCCR_OFS_CLK_DIV 8'h18
`define UCCR_OFS_WAKE 8'h1F
`define UCCR_OFS_TX_PURGE 8'h40
`define UCCR_OFS_TX_EXT 8'h42
`define UCCR_OFS_RX_PURGE 8'h43
`define UCCR_OFS_RX_EXT 8'h45
`define UCCR_OFS_QUICK 8'h46
`define UCCR_OFS_RX_TRIG 8'h47
`define UCCR_OFS_HOST_FLAG 8'h60
`define UCCR_OFS_SLEEP_LVL 8'h6A
`define UCCR_OFS_SLEEP_BHV 8'h6B
`define UCCR_MASK_PIN_DRIVE 16'h0BFF
`define UCCR_MASK_PULL_HIGH 16'h07FF
`define UCCR_MASK_PULL_LOW 16'h07FF
`define UCCR_MASK_WRAP 16'h0007
`define UCCR_MASK_INFRARED 16'h0007
`define UCCR_MASK_CLK_DIV 16'hFFFF
`define UCCR_MASK_WAKE 16'h000C
`define UCCR_MASK_TX_PURGE 16'h0007
`define UCCR_MASK_TX_EXT 16'h0001
`define UCCR_MASK_RX_PURGE 16'h0007
`define UCCR_MASK_RX_EXT 16'h0001
`define UCCR_MASK_QUICK 16'h0001
`define UCCR_MASK_RX_TRIG 16'h03FF
`define UCCR_MASK_HOST_FLAG 16'h0001
`define UCCR_MASK_SLEEP_LVL 16'h3CCF
`define UCCR_MASK_SLEEP_BHV 16'hBCCF
`define UCCR_MISC_RST 16'h0000
`endif

// ---- uccr_regs.v ----
/*
  Per-channel control register bank for a two-channel serial bridge: enable and
  pacing registers for each channel, the version and link status registers, and
  the per-channel gating that the pacing mode implies.
  Assumes the request decoder presents one request per strobe on the same clock,
  and the serial engines report transmit activity and address match on this clock.
*/
`include "uccr_defs.vh"
`default_nettype none
module uccr_regs #(
  parameter [15:0] SILICON_VERSION = 16'h0001 // arbitrary value
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_ce,
  // request port
  input wire i_req_valid,
  input wire [2:0] i_req_kind,
  input wire [7:0] i_req_index_lo,
  input wire [7:0] i_req_index_hi,
  input wire [15:0] i_req_wdata,
  output reg o_rsp_valid,
  output reg o_rsp_error,
  output reg [15:0] o_rsp_rdata,
  // serial engine status, per channel (bit 0 channel A, bit 1 channel B)
  input wire [1:0] i_tx_busy,
  input wire [1:0] i_addr_match,
  // controls to the serial engines
  output reg [1:0] o_tx_enable,
  output reg [1:0] o_rx_enable,
  output reg [1:0] o_rx_accept,
  output reg [1:0] o_tx_permit,
  output reg [1:0] o_hw_flow,
  output reg [1:0] o_sw_flow
);
  // per-channel enable and pacing words; index 0 is channel A, 1 is channel B
  reg [15:0] chan_on_r [0:1];
  reg [15:0] pacing_r [0:1];
  reg [15:0] link_stat_r;

  // request decode
  reg is_gen_wr;
  reg is_gen_rd;
  reg is_gen;
  reg ch_ok;
  reg ch_sel;
  reg hit_chan_on;
  reg hit_pacing;
  reg hit_misc;
  reg [3:0] misc_idx;
  reg [15:0] misc_mask;
  wire [4:0] misc_slot;
  wire [15:0] misc_q [0:31];
  reg [15:0] rdata_nxt;
  reg err_nxt;
  reg wr_chan_on;
  reg wr_pacing;
  reg wr_misc;
  reg wr_link;

  // per-channel gating terms, one bit per channel
  wire [1:0] tx_on;
  wire [1:0] rx_on;
  wire [1:0] rx_ok;
  wire [1:0] tx_ok;
  wire [1:0] hw_mode;
  wire [1:0] sw_mode;

  always @* begin
    is_gen_wr = (i_req_kind == `UCCR_REQ_GENERIC_WR);
    is_gen_rd = (i_req_kind == `UCCR_REQ_GENERIC_RD);
    is_gen = is_gen_wr || is_gen_rd;
    ch_ok = (i_req_index_hi == `UCCR_CHAN_A) || (i_req_index_hi == `UCCR_CHAN_B);
    ch_sel = (i_req_index_hi == `UCCR_CHAN_B);
    hit_chan_on = (i_req_index_lo == `UCCR_OFS_CHAN_ON);
    hit_pacing = (i_req_index_lo == `UCCR_OFS_PACING);
  end

  // other per-channel settings: entry number and writable bits of each address
  always @* begin
    hit_misc = 1'b1;
    misc_idx = 4'h0;
    misc_mask = 16'h0000;
    case (i_req_index_lo)
      `UCCR_OFS_PIN_DRIVE: begin
        misc_idx = 4'h0;
        misc_mask = `UCCR_MASK_PIN_DRIVE;
      end
      `UCCR_OFS_PULL_HIGH: begin
        misc_idx = 4'h1;
        misc_mask = `UCCR_MASK_PULL_HIGH;
      end
      `UCCR_OFS_PULL_LOW: begin
        misc_idx = 4'h2;
        misc_mask = `UCCR_MASK_PULL_LOW;
      end
      `UCCR_OFS_WRAP: begin
        misc_idx = 4'h3;
        misc_mask = `UCCR_MASK_WRAP;
      end
      `UCCR_OFS_INFRARED: begin
        misc_idx = 4'h4;
        misc_mask = `UCCR_MASK_INFRARED;
      end
      `UCCR_OFS_CLK_DIV: begin
        misc_idx = 4'h5;
        misc_mask = `UCCR_MASK_CLK_DIV;
      end
      `UCCR_OFS_WAKE: begin
        misc_idx = 4'h6;
        misc_mask = `UCCR_MASK_WAKE;
      end
      `UCCR_OFS_TX_PURGE: begin
        misc_idx = 4'h7;
        misc_mask = `UCCR_MASK_TX_PURGE;
      end
      `UCCR_OFS_TX_EXT: begin
        misc_idx = 4'h8;
        misc_mask = `UCCR_MASK_TX_EXT;
      end
      `UCCR_OFS_RX_PURGE: begin
        misc_idx = 4'h9;
        misc_mask = `UCCR_MASK_RX_PURGE;
      end
      `UCCR_OFS_RX_EXT: begin
        misc_idx = 4'hA;
        misc_mask = `UCCR_MASK_RX_EXT;
      end
      `UCCR_OFS_QUICK: begin
        misc_idx = 4'hB;
        misc_mask = `UCCR_MASK_QUICK;
      end
      `UCCR_OFS_RX_TRIG: begin
        misc_idx = 4'hC;
        misc_mask = `UCCR_MASK_RX_TRIG;
      end
      `UCCR_OFS_HOST_FLAG: begin
        misc_idx = 4'hD;
        misc_mask = `UCCR_MASK_HOST_FLAG;
      end
      `UCCR_OFS_SLEEP_LVL: begin
        misc_idx = 4'hE;
        misc_mask = `UCCR_MASK_SLEEP_LVL;
      end
      `UCCR_OFS_SLEEP_BHV: begin
        misc_idx = 4'hF;
        misc_mask = `UCCR_MASK_SLEEP_BHV;
      end
      default: begin
        hit_misc = 1'b0;
      end
    endcase
  end

  assign misc_slot = {ch_sel, misc_idx};

  // answer data and refusal; writes answer zero, link status writes return the old word
  always @* begin
    rdata_nxt = 16'h0000;
    err_nxt = 1'b0;
    case (i_req_kind)
      `UCCR_REQ_GENERIC_RD, `UCCR_REQ_GENERIC_WR: begin
        if (!ch_ok) begin
          err_nxt = 1'b1;
        end else if (hit_chan_on) begin
          rdata_nxt = chan_on_r[ch_sel];
        end else if (hit_pacing) begin
          rdata_nxt = pacing_r[ch_sel];
        end else if (hit_misc) begin
          rdata_nxt = misc_q[misc_slot];
        end else begin
          // version, link status and the queue levels are not reachable this way
          err_nxt = 1'b1;
        end
      end
      `UCCR_REQ_VERSION_RD: begin
        rdata_nxt = SILICON_VERSION;
      end
      `UCCR_REQ_LSTAT_RD, `UCCR_REQ_LSTAT_WR: begin
        rdata_nxt = link_stat_r;
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
    if (is_gen_wr) begin
      rdata_nxt = 16'h0000;
    end
  end

  // write strobes; a refused request writes nothing
  always @* begin
    wr_chan_on = i_req_valid && is_gen && is_gen_wr && ch_ok && hit_chan_on;
    wr_pacing = i_req_valid && is_gen_wr && ch_ok && hit_pacing;
    wr_misc = i_req_valid && is_gen_wr && ch_ok && hit_misc;
    wr_link = i_req_valid && (i_req_kind == `UCCR_REQ_LSTAT_WR);
  end

  // enable, pacing and link status; enable and pacing reserved bits are dropped so they read zero, link status keeps all 16 bits
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      chan_on_r[0] <= `UCCR_CHAN_ON_RST;
      chan_on_r[1] <= `UCCR_CHAN_ON_RST;
      pacing_r[0] <= `UCCR_PACING_RST;
      pacing_r[1] <= `UCCR_PACING_RST;
      link_stat_r <= `UCCR_LINK_STAT_RST;
    end else if (i_ce) begin
      if (wr_chan_on) begin
        chan_on_r[ch_sel] <= i_req_wdata & `UCCR_CHAN_ON_MASK;
      end
      if (wr_pacing) begin
        // a write while enabled is accepted; the result is left to software
        pacing_r[ch_sel] <= i_req_wdata & `UCCR_PACING_MASK;
      end
      if (wr_link) begin
        link_stat_r <= i_req_wdata;
      end
    end
  end

  // one answer per request, one cycle later; data and error stand until the next one
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_error <= 1'b0;
      o_rsp_rdata <= 16'h0000;
    end else if (i_ce) begin
      o_rsp_valid <= i_req_valid;
      if (i_req_valid) begin
        o_rsp_error <= err_nxt;
        o_rsp_rdata <= rdata_nxt;
      end
    end
  end

  // other settings are plain storage for the engines; the queue levels have no source here
  genvar e;
  generate
    for (e = 0; e < 32; e = e + 1) begin : slot
      reg [15:0] word_r;
      always @(posedge i_ref_clk) begin
        if (i_srst) begin
          word_r <= `UCCR_MISC_RST;
        end else if (i_ce && wr_misc && ({27'h0, misc_slot} == e)) begin
          word_r <= i_req_wdata & misc_mask;
        end
      end
      assign misc_q[e] = word_r;
    end
  endgenerate

  // per-channel gating from the pacing mode
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      wire [2:0] mode = pacing_r[g][2:0];
      wire half = pacing_r[g][`UCCR_BIT_HALF_DUPLEX];
      reg rx_gate;
      reg tx_gate;
      always @* begin
        rx_gate = 1'b1;
        tx_gate = 1'b1;
        case (mode)
          `UCCR_MODE_NONE, `UCCR_MODE_HW, `UCCR_MODE_SW: begin
            rx_gate = 1'b1;
            tx_gate = 1'b1;
          end
          `UCCR_MODE_MD_RX: begin
            rx_gate = i_addr_match[g];
            tx_gate = 1'b1;
          end
          `UCCR_MODE_MD_ALL: begin
            rx_gate = i_addr_match[g];
            tx_gate = i_addr_match[g];
          end
          default: begin
            // reserved codes behave as mode 0
            rx_gate = 1'b1;
            tx_gate = 1'b1;
          end
        endcase
        if (half && i_tx_busy[g]) begin
          rx_gate = 1'b0;
        end
      end
      assign rx_ok[g] = rx_gate;
      assign tx_ok[g] = tx_gate;
      assign tx_on[g] = chan_on_r[g][`UCCR_BIT_TX_EN];
      assign rx_on[g] = chan_on_r[g][`UCCR_BIT_RX_EN];
      assign hw_mode[g] = (mode == `UCCR_MODE_HW);
      assign sw_mode[g] = (mode == `UCCR_MODE_SW);
    end
  endgenerate

  // controls to the serial engines; one process so each output has a single driver
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_tx_enable <= 2'h0;
      o_rx_enable <= 2'h0;
      o_rx_accept <= 2'h0;
      o_tx_permit <= 2'h0;
      o_hw_flow <= 2'h0;
      o_sw_flow <= 2'h0;
    end else if (i_ce) begin
      o_tx_enable <= tx_on;
      o_rx_enable <= rx_on;
      o_rx_accept <= rx_on & rx_ok;
      o_tx_permit <= tx_on & tx_ok;
      o_hw_flow <= hw_mode;
      o_sw_flow <= sw_mode;
    end
  end
endmodule
`default_nettype wire

// ---- uccr_regs_asserts.sv ----
/* checker for uccr_regs: request and answer ports only; one clock, sync reset */
`default_nettype none
module uccr_regs_asserts #(parameter logic [15:0] VER = 16'h0001) (
  // watched ports
  input wire logic i_ref_clk, i_srst, i_ce, i_req_valid, o_rsp_valid, o_rsp_error,
  input wire logic [2:0] i_req_kind,
  input wire logic [7:0] i_req_index_lo, i_req_index_hi,
  input wire logic [15:0] o_rsp_rdata
);
  timeunit 1ns / 1ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  wire logic [2:0] k = i_req_kind;
  wire logic [15:0] ix = {i_req_index_hi, i_req_index_lo};
  wire logic tk = i_req_valid && i_ce;
  property p_ans; tk |=> o_rsp_valid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_chan; tk && k == 3'h2 && ix[8] |=> o_rsp_error; endproperty
  a_chan: assert property (p_chan) else $error("odd channel taken");
  property p_ver; tk && k == 3'h3 |=> o_rsp_rdata == VER; endproperty
  a_ver: assert property (p_ver) else $error("version value");
  property p_hid; tk && k inside {3'h1, 3'h2} && ix[7:0] == 8'h62 |=> o_rsp_error;
  endproperty
  a_hid: assert property (p_hid) else $error("special register reached");
  property p_kind; tk && k > 3'h5 |=> o_rsp_error; endproperty
  a_kind: assert property (p_kind) else $error("unknown kind taken");
  property p_wr; tk && k == 3'h1 |=> o_rsp_rdata == 16'h0000; endproperty
  a_wr: assert property (p_wr) else $error("write returned data");
  property p_err; o_rsp_valid && o_rsp_error |-> o_rsp_rdata == 16'h0000; endproperty
  a_err: assert property (p_err) else $error("refusal returned data");
  property p_rst; $fell(i_srst) |-> !o_rsp_valid && o_rsp_rdata == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_ver: cover property (i_req_valid && k == 3'h3);
  c_link: cover property (i_req_valid && k == 3'h5);
  c_err: cover property (o_rsp_valid && o_rsp_error);
endmodule
bind uccr_regs uccr_regs_asserts #(.VER(SILICON_VERSION)) uccr_regs_asserts_i (.i_ref_clk,
  .i_srst, .i_ce, .i_req_valid, .o_rsp_valid, .o_rsp_error, .i_req_kind, .i_req_index_lo,
  .i_req_index_hi, .o_rsp_rdata);
`default_nettype wire

// ---- uccr_host_model.sv ----
/* host model: one vendor request at a time; expects the answer one cycle later */
`default_nettype none
module uccr_host_model (
  // request out, answer in
  input wire logic i_ref_clk, i_rsp_error,
  input wire logic [15:0] i_rsp_rdata,
  output logic o_req_valid,
  output logic [2:0] o_req_kind,
  output logic [7:0] o_req_hi, o_req_lo,
  output logic [15:0] o_req_wdata
);
  timeunit 1ns / 1ps;
  initial {o_req_valid, o_req_kind, o_req_hi, o_req_lo, o_req_wdata} = '0;
  task automatic xfer(input logic [2:0] kd, input logic [15:0] ix, wdat, output logic er,
    output logic [15:0] rd);
    @(posedge i_ref_clk);
    {o_req_valid, o_req_kind, o_req_hi, o_req_lo, o_req_wdata} <= {1'b1, kd, ix, wdat};
    @(posedge i_ref_clk);
    o_req_valid <= 1'b0;
    o_req_wdata <= ~wdat; // stale data must not pass for a fresh write
    #1 er = i_rsp_error;
    rd = i_rsp_rdata;
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/* bench for uccr_regs; host model sends requests, serial status is driven here */
`default_nettype none
module tb_top;
  timeunit 1ns / 1ps;
  localparam logic [15:0] VER = 16'h5A3C; // arbitrary value
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic v, e, ge, rv;
  logic [1:0] txe, rxe, busy = 2'h1;
  logic [2:0] k;
  logic [7:0] lo, hi;
  logic [15:0] wd, d, gd;
  logic [1:0] rxa, txp, hwf, swf, mat = 2'h0;
  int failures = 0;
  int total_checks = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  uccr_regs #(.SILICON_VERSION(VER)) uccr_regs_i (.i_ref_clk, .i_srst, .i_ce(1'b1),
    .i_req_valid(v), .i_req_kind(k), .i_req_index_lo(lo), .i_req_index_hi(hi),
    .i_req_wdata(wd), .o_rsp_valid(rv), .o_rsp_error(e), .o_rsp_rdata(d), .i_tx_busy(busy),
    .i_addr_match(mat), .o_tx_enable(txe), .o_rx_enable(rxe), .o_rx_accept(rxa),
    .o_tx_permit(txp), .o_hw_flow(hwf), .o_sw_flow(swf));
  uccr_host_model uccr_host_model_i (.i_ref_clk, .o_req_valid(v), .o_req_kind(k),
    .o_req_hi(hi), .o_req_lo(lo), .o_req_wdata(wd), .i_rsp_error(e), .i_rsp_rdata(d));
  task chk(input string n, input logic [15:0] ex, sn);
    total_checks++;
    if (sn !== ex) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, ex, sn);
    end
  endtask
  task rq(input logic [2:0] kd, input logic [15:0] ix, wdat, input logic ee,
    input logic [15:0] er);
    uccr_host_model_i.xfer(kd, ix, wdat, ge, gd);
    chk("valid", 16'h0001, {15'h0, rv});
    chk("err", {15'h0, ee}, {15'h0, ge});
    chk("rdata", er, gd);
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge i_ref_clk);
    failures++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rq(3'h2, 16'h0006, 16'h0, 0, 16'h0);
    for (int m = 0; m < 5; m++) begin
      for (int t = 0; t < 2; t++) begin
        @(posedge i_ref_clk);
        mat <= {1'b0, t[0]};
        busy <= {1'b0, ~t[0]};
        rq(3'h1, 16'h0006, {12'h0, m == 1, m[2:0]}, 0, 16'h0);
        rq(3'h2, 16'h0006, 16'h0, 0, {12'h0, m == 1, m[2:0]});
        rq(3'h1, 16'h0000, 16'h3, 0, 16'h0);
        repeat (2) @(posedge i_ref_clk);
        #1 chk("gate", {9'h0, m == 1, 1'b0, m == 2, 1'b0, m != 4 || t, 1'b0,
          (m < 3 || t) && (m != 1 || t)}, {8'h0, hwf, swf, txp, rxa});
        chk("enables", 16'h0005, {12'h0, rxe, txe});
        rq(3'h1, 16'h0000, 16'h0, 0, 16'h0);
      end
    end
    rq(3'h3, 16'h0260, 16'h0, 0, VER);
    rq(3'h2, 16'h0262, 16'h0, 1, 16'h0);
    rq(3'h4, 16'h0262, 16'hBEEF, 0, 16'h0);
    rq(3'h5, 16'h0262, 16'h0, 0, 16'hBEEF);
    rq(3'h2, 16'h0100, 16'h0, 1, 16'h0);
    rq(3'h7, 16'h0000, 16'h0, 1, 16'h0);
    rq(3'h1, 16'h0200, 16'h3, 0, 16'h0);
    rq(3'h2, 16'h0000, 16'h0, 0, 16'h0);
    rq(3'h1, 16'h0213, 16'h0BFF, 0, 16'h0);
    rq(3'h2, 16'h0213, 16'h0, 0, 16'h0BFF);
    rq(3'h2, 16'h0013, 16'h0, 0, 16'h0);
    give_verdict;
  end
endmodule
`default_nettype wire
